// ==== core/tcpc_top.v ====
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tcpc_defines.vh"
// Behaviour
// - Three-bit field picks the count source
// - Async bit one: input not synchronised
// - Async bit zero: synchronise to instruction clock
// - Prescale divides by two to field value
// - Unimplemented bits read back as zero
// - Narrow mode: high register is period
// - Wide mode: high register is count high
module tcpc_top #(
    parameter PS_W = 4,
    parameter PS_CNT_W = 15
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // Count sources
    input wire remappable_pin_input,
    input wire high_freq_internal_osc,
    input wire low_freq_internal_osc,
    input wire secondary_oscillator,
    input wire logic_cell_one_output,
    // Timer outputs
    output reg timer_out,
    output reg timer_overflow_flag,
    output wire timer_irq
);
    // ==========================================
    // Reset release through two flops
    reg [1:0] rst_sync_reg;
    wire rst_n;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    // Only the second flop drives the internal reset
    assign rst_n = rst_sync_reg[1];

    // ==========================================
    // Registers
    reg [7:0] timer_count_low_reg;
    reg [7:0] timer_period_or_count_high_reg;
    reg [7:0] timer_main_control_reg;
    reg [7:0] timer_clock_control_reg;
    reg timer_overflow_irq_enable_reg;
    reg [3:0] post_cnt_reg;
    reg [1:0] instr_phase_reg;
    reg async_last_reg;

    // Field views of the control registers
    wire timer_enable = timer_main_control_reg[`TCPC_MAIN_ENABLE_BIT];
    wire wide_count_select = timer_main_control_reg[`TCPC_MAIN_WIDE_BIT];
    wire [3:0] post_select = timer_main_control_reg[`TCPC_MAIN_POST_MSB:`TCPC_MAIN_POST_LSB];
    wire [2:0] count_source_select = timer_clock_control_reg[`TCPC_CLK_SRC_MSB:`TCPC_CLK_SRC_LSB];
    wire input_async_enable = timer_clock_control_reg[`TCPC_CLK_ASYNC_BIT];
    wire [PS_W-1:0] prescale_select = timer_clock_control_reg[`TCPC_CLK_PS_MSB:`TCPC_CLK_PS_LSB];

    // ==========================================
    // APB decode
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pwrite;

    // Mapped register offsets
    function addr_hit;
        input [11:0] a;
        begin
            case (a)
                `TCPC_ADDR_COUNT_LOW,
                `TCPC_ADDR_PERIOD_HIGH,
                `TCPC_ADDR_MAIN_CTRL,
                `TCPC_ADDR_CLOCK_CTRL,
                `TCPC_ADDR_IRQ_STATUS,
                `TCPC_ADDR_IRQ_MASK: addr_hit = 1'b1;
                default: addr_hit = 1'b0;
            endcase
        end
    endfunction

    // One write strobe per register
    wire wr_low = apb_wr & (paddr == `TCPC_ADDR_COUNT_LOW);
    wire wr_high = apb_wr & (paddr == `TCPC_ADDR_PERIOD_HIGH);
    wire wr_main = apb_wr & (paddr == `TCPC_ADDR_MAIN_CTRL);
    wire wr_clk = apb_wr & (paddr == `TCPC_ADDR_CLOCK_CTRL);
    wire wr_stat = apb_wr & (paddr == `TCPC_ADDR_IRQ_STATUS);
    wire wr_mask = apb_wr & (paddr == `TCPC_ADDR_IRQ_MASK);

    // Zero-wait slave; error on unmapped address
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_hit(paddr);

    // ==========================================
    // Instruction clock phase (system clock over four)
    // Tick on the last phase of each instruction cycle
    wire instr_tick = (instr_phase_reg == `TCPC_INSTR_PHASE_LAST);
    wire instr_level = instr_phase_reg[1];

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_phase_reg <= 2'b00;
        end else begin
            instr_phase_reg <= instr_phase_reg + 2'b01;
        end
    end

    // ==========================================
    // Count source multiplexer
    reg src_level;

    always @* begin
        case (count_source_select)
            `TCPC_SRC_PIN: src_level = remappable_pin_input;
            `TCPC_SRC_PIN_INV: src_level = ~remappable_pin_input;
            `TCPC_SRC_INSTR: src_level = instr_level;
            `TCPC_SRC_HFOSC: src_level = high_freq_internal_osc;
            `TCPC_SRC_LFOSC: src_level = low_freq_internal_osc;
            `TCPC_SRC_SECONDARY_OSCILLATOR: src_level = secondary_oscillator;
            `TCPC_SRC_LOGIC: src_level = logic_cell_one_output;
            default: src_level = 1'b0; // Reserved code gives no count
        endcase
    end

    // ==========================================
    // Synchronised path, sampled at instruction rate
    wire sync_rise;

    tcpc_sync #(
        .STAGES(`TCPC_SYNC_STAGES)
    ) u_sync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .sample_en(instr_tick),
        .din(src_level),
        .rise(sync_rise)
    );

    // Unsynchronised path: direct rising edge
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            async_last_reg <= 1'b0;
        end else begin
            async_last_reg <= src_level;
        end
    end

    // Edge between two system clock samples
    wire async_rise = src_level & ~async_last_reg;

    // ==========================================
    // Count pulse selection
    // Synchronised instruction clock counts on each instruction tick
    // Its phase bit sampled at one fixed phase never shows an edge
    reg sel_pulse;

    always @* begin
        if (input_async_enable) begin
            sel_pulse = async_rise;
        end else if (count_source_select == `TCPC_SRC_INSTR) begin
            sel_pulse = instr_tick;
        end else begin
            sel_pulse = sync_rise;
        end
    end

    // Pulses reach the prescaler only while enabled
    wire count_pulse = timer_enable & sel_pulse;

    // ==========================================
    // Prescaler; cleared by count writes
    wire ps_tick;

    tcpc_prescaler #(
        .SEL_W(PS_W),
        .CNT_W(PS_CNT_W)
    ) u_prescaler (
        .clk(ref_clk),
        .rst_n(rst_n),
        .clear(wr_low | wr_high | ~timer_enable),
        .sel(prescale_select),
        .in_pulse(count_pulse),
        .out_tick(ps_tick)
    );

    // ==========================================
    // Counter and overflow detect
    wire narrow_match = (timer_count_low_reg == timer_period_or_count_high_reg);
    wire wide_roll = (timer_count_low_reg == 8'hFF) && (timer_period_or_count_high_reg == 8'hFF);
    // Overflow event per mode
    wire ovf_tick = ps_tick & (wide_count_select ? wide_roll : narrow_match);
    // Every (N+1)th overflow event sets the flag
    wire post_done = ovf_tick & (post_cnt_reg == post_select);

    // Count registers
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_count_low_reg <= `TCPC_RST_COUNT_LOW;
            timer_period_or_count_high_reg <= `TCPC_RST_PERIOD_HIGH;
        end else begin
            if (wr_low) begin
                timer_count_low_reg <= pwdata[7:0];
            end else if (ps_tick) begin
                if (!wide_count_select && narrow_match) begin
                    timer_count_low_reg <= 8'h00;
                end else begin
                    timer_count_low_reg <= timer_count_low_reg + 8'h01;
                end
            end
            if (wr_high) begin
                timer_period_or_count_high_reg <= pwdata[7:0];
            end else if (ps_tick && wide_count_select && timer_count_low_reg == 8'hFF) begin
                timer_period_or_count_high_reg <= timer_period_or_count_high_reg + 8'h01;
            end
        end
    end

    // Postscaler and output toggle
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            post_cnt_reg <= 4'h0;
            timer_out <= 1'b0;
        end else begin
            if (wr_main || post_done) begin
                post_cnt_reg <= 4'h0;
            end else if (ovf_tick) begin
                post_cnt_reg <= post_cnt_reg + 4'h1;
            end
            if (post_done) begin
                timer_out <= ~timer_out;
            end
        end
    end

    // ==========================================
    // Control registers
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_main_control_reg <= `TCPC_RST_MAIN_CTRL;
            timer_clock_control_reg <= `TCPC_RST_CLOCK_CTRL;
        end else begin
            if (wr_main) begin
                timer_main_control_reg <= {pwdata[7], 2'b00, pwdata[4:0]};
            end
            if (wr_clk) begin
                timer_clock_control_reg <= pwdata[7:0];
            end
        end
    end

    // Overflow flag and mask; set beats clear
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_overflow_flag <= 1'b0;
            timer_overflow_irq_enable_reg <= 1'b0;
        end else begin
            if (post_done) begin
                timer_overflow_flag <= 1'b1;
            end else if (wr_stat && pwdata[`TCPC_IRQ_OVF_BIT]) begin
                timer_overflow_flag <= 1'b0;
            end
            if (wr_mask) begin
                timer_overflow_irq_enable_reg <= pwdata[`TCPC_IRQ_OVF_BIT];
            end
        end
    end

    // Level request while flag and enable are both set
    assign timer_irq = timer_overflow_flag & timer_overflow_irq_enable_reg;

    // ==========================================
    // Read data, captured in the setup phase
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup) begin
            case (paddr)
                `TCPC_ADDR_COUNT_LOW: prdata <= {24'h00_0000, timer_count_low_reg};
                `TCPC_ADDR_PERIOD_HIGH: prdata <= {24'h00_0000, timer_period_or_count_high_reg};
                `TCPC_ADDR_MAIN_CTRL: prdata <= {24'h00_0000, timer_enable, 1'b0, timer_out,
                                                 timer_main_control_reg[4:0]};
                `TCPC_ADDR_CLOCK_CTRL: prdata <= {24'h00_0000, timer_clock_control_reg};
                `TCPC_ADDR_IRQ_STATUS: prdata <= {31'h0000_0000, timer_overflow_flag};
                `TCPC_ADDR_IRQ_MASK: prdata <= {31'h0000_0000, timer_overflow_irq_enable_reg};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== core/tcpc_defines.vh ====
`ifndef TCPC_DEFINES_VH
`define TCPC_DEFINES_VH
// ==========================================
// Register byte addresses
`define TCPC_ADDR_COUNT_LOW 12'h000
`define TCPC_ADDR_PERIOD_HIGH 12'h004
`define TCPC_ADDR_MAIN_CTRL 12'h008
`define TCPC_ADDR_CLOCK_CTRL 12'h00C
`define TCPC_ADDR_IRQ_STATUS 12'h010
`define TCPC_ADDR_IRQ_MASK 12'h014
// ==========================================
// Reset values
`define TCPC_RST_COUNT_LOW 8'h00
`define TCPC_RST_PERIOD_HIGH 8'hFF
`define TCPC_RST_MAIN_CTRL 8'h00
`define TCPC_RST_CLOCK_CTRL 8'h00
// ==========================================
// Main control fields
`define TCPC_MAIN_ENABLE_BIT 7
`define TCPC_MAIN_OUT_BIT 5
`define TCPC_MAIN_WIDE_BIT 4
`define TCPC_MAIN_POST_MSB 3
`define TCPC_MAIN_POST_LSB 0
// Clock control fields
`define TCPC_CLK_SRC_MSB 7
`define TCPC_CLK_SRC_LSB 5
`define TCPC_CLK_ASYNC_BIT 4
`define TCPC_CLK_PS_MSB 3
`define TCPC_CLK_PS_LSB 0
// Interrupt status and mask bit
`define TCPC_IRQ_OVF_BIT 0
// ==========================================
// Count source codes
`define TCPC_SRC_PIN 3'h0
`define TCPC_SRC_PIN_INV 3'h1
`define TCPC_SRC_INSTR 3'h2
`define TCPC_SRC_HFOSC 3'h3
`define TCPC_SRC_LFOSC 3'h4
`define TCPC_SRC_RSVD 3'h5
`define TCPC_SRC_SECONDARY_OSCILLATOR 3'h6
`define TCPC_SRC_LOGIC 3'h7
// ==========================================
// Timing: instruction clock is system clock over four
`define TCPC_INSTR_DIV 4
`define TCPC_INSTR_PHASE_LAST 2'h3
`define TCPC_SYNC_STAGES 2
`endif

// ==== core/tcpc_sync.v ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Synchroniser with sample enable and rise pulse
module tcpc_sync #(
    parameter STAGES = 2
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Sampling
    input wire sample_en,
    input wire din,
    // Result
    output wire rise
);
    reg [STAGES-1:0] chain_reg;
    reg last_reg;

    // Shift chain, advanced only on sample ticks
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chain_reg <= {STAGES{1'b0}};
            last_reg <= 1'b0;
        end else if (sample_en) begin
            chain_reg <= {chain_reg[STAGES-2:0], din};
            last_reg <= chain_reg[STAGES-1];
        end
    end

    // Edge seen on the last stage only
    assign rise = sample_en & chain_reg[STAGES-1] & ~last_reg;
endmodule
`default_nettype wire

// ==== core/tcpc_prescaler.v ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Power-of-two prescaler, 1:1 to 1:2^(2^SEL_W - 1)
module tcpc_prescaler #(
    parameter SEL_W = 4,
    parameter CNT_W = 15
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Control
    input wire clear,
    input wire [SEL_W-1:0] sel,
    // Count pulses
    input wire in_pulse,
    output wire out_tick
);
    reg [CNT_W-1:0] cnt_reg;
    reg [CNT_W-1:0] mask;
    integer i;

    // Terminal count mask: sel low bits set
    always @* begin
        mask = {CNT_W{1'b0}};
        for (i = 0; i < CNT_W; i = i + 1) begin
            if (i < sel) begin
                mask[i] = 1'b1;
            end
        end
    end

    assign out_tick = in_pulse & ((cnt_reg & mask) == mask);

    // Divider counter
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= {CNT_W{1'b0}};
        end else if (clear || out_tick) begin
            cnt_reg <= {CNT_W{1'b0}};
        end else if (in_pulse) begin
            cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

// ==== sim/tcpc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcpc_defines.vh"
// ==========================================
// Port checker for the timer front end
module tcpc_chk #(
    parameter PS_W = 4,
    parameter PS_CNT_W = 15
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // Timer outputs
    input wire logic timer_out,
    input wire logic timer_overflow_flag,
    input wire logic timer_irq
);
    logic [7:0] clk_ctrl_reg;
    logic mask_reg;
    logic en_reg;
    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite;
    wire mapped = paddr <= `TCPC_ADDR_IRQ_MASK && paddr[1:0] == 2'h0;
    wire clr = wr && paddr == `TCPC_ADDR_IRQ_STATUS && pwdata[0];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Shadow of the written control bits
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_ctrl_reg <= 8'h00;
            mask_reg <= 1'b0;
            en_reg <= 1'b0;
        end else if (wr) begin
            if (paddr == `TCPC_ADDR_CLOCK_CTRL) clk_ctrl_reg <= pwdata[7:0];
            if (paddr == `TCPC_ADDR_IRQ_MASK) mask_reg <= pwdata[0];
            if (paddr == `TCPC_ADDR_MAIN_CTRL) en_reg <= pwdata[7];
        end
    end
    // Assertions
    a_irq_mask_level: assert property (timer_irq == (timer_overflow_flag && mask_reg))
        else $error("irq level differs from flag and mask");
    a_unmapped_refused: assert property (rd && !mapped |-> prdata == 32'h0000_0000 && pslverr)
        else $error("unmapped read not refused");
    a_mapped_no_err: assert property ((rd || wr) && mapped |-> !pslverr)
        else $error("error on mapped access");
    a_ready_held: assert property (psel |-> pready)
        else $error("ready low during a transfer");
    a_upper_bits_zero: assert property (rd |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_ctrl_gap_zero: assert property (rd && paddr == `TCPC_ADDR_MAIN_CTRL |-> !prdata[6])
        else $error("unused control bit reads one");
    a_clock_ctrl_back: assert property (rd && paddr == `TCPC_ADDR_CLOCK_CTRL |-> prdata[7:0] == clk_ctrl_reg)
        else $error("clock control readback wrong");
    a_flag_sticky: assert property ($fell(timer_overflow_flag) |-> $past(clr))
        else $error("flag cleared without write");
    a_rise_toggles_out: assert property ($rose(timer_overflow_flag) |-> timer_out != $past(timer_out))
        else $error("output did not toggle on overflow");
    a_idle_no_count: assert property (!en_reg && !$past(en_reg) |-> !$rose(timer_overflow_flag))
        else $error("overflow while disabled");
    // Main scenarios
    c_overflow: cover property ($rose(timer_overflow_flag));
    c_irq: cover property (timer_irq);
    c_unmapped: cover property (rd && !mapped);
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcpc_defines.vh"
// ==========================================
// Self-checking bench
module testbench;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rd;
    logic [4:0] src = 5'h00; // pin, hf, lf, secondary_oscillator, logic cell
    wire pready, pslverr, timer_out, timer_overflow_flag, timer_irq;
    wire [31:0] prdata;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0;
    tcpc_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .remappable_pin_input(src[0]), .high_freq_internal_osc(src[1]), .low_freq_internal_osc(src[2]),
        .secondary_oscillator(src[3]), .logic_cell_one_output(src[4]), .timer_out(timer_out),
        .timer_overflow_flag(timer_overflow_flag), .timer_irq(timer_irq));
    // Clock and cycle count
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer, waits for ready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        check("pslverr", pslverr, a > `TCPC_ADDR_IRQ_MASK);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Wait for the overflow flag, note the cycle
    task automatic wait_flag(input int lim);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (timer_overflow_flag !== 1'b1 && n < lim);
        t0 = cyc;
        check("overflow flag", timer_overflow_flag, 1'b1);
    endtask
    // Stop, load, clear flag, start
    task automatic setup(input logic [7:0] ctl, input logic [7:0] main, input logic [7:0] per);
        apb(1'b1, `TCPC_ADDR_MAIN_CTRL, 32'h0000_0000);
        apb(1'b1, `TCPC_ADDR_CLOCK_CTRL, {24'h00_0000, ctl});
        apb(1'b1, `TCPC_ADDR_PERIOD_HIGH, {24'h00_0000, per});
        apb(1'b1, `TCPC_ADDR_COUNT_LOW, {24'h00_0000, main[4] ? 8'hFD : 8'h00});
        repeat (12) @(posedge ref_clk);
        apb(1'b1, `TCPC_ADDR_IRQ_STATUS, 32'h0000_0001);
        apb(1'b1, `TCPC_ADDR_MAIN_CTRL, {24'h00_0000, main});
    endtask
    // Rising edges on chosen sources, ending high
    task automatic pulse(input logic [4:0] m);
        repeat (4) begin
            src <= 5'h00;
            repeat (6) @(posedge ref_clk);
            src <= m;
            repeat (6) @(posedge ref_clk);
        end
        repeat (10) @(posedge ref_clk);
    endtask
    task automatic close_out;
        $display("err_count %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        close_out();
    end
    // Main sequence
    initial begin
        int pss[4] = '{0, 1, 8, 9};
        int k, p, c, e;
        logic [7:0] v;
        logic [4:0] m;
        void'($urandom(29));
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (k = 0; k < 7; k++) begin
            apb(1'b0, 12'(k * 4), 32'h0000_0000);
            check("reset value", rd, k == 1 ? 32'h0000_00FF : 32'h0000_0000);
        end
        repeat (4) begin
            v = 8'($urandom);
            apb(1'b1, `TCPC_ADDR_MAIN_CTRL, {24'($urandom), v & 8'h5F});
            apb(1'b0, `TCPC_ADDR_MAIN_CTRL, 32'h0000_0000);
            check("main ctrl", rd, {24'h00_0000, v & 8'h1F});
            apb(1'b1, `TCPC_ADDR_CLOCK_CTRL, {24'($urandom), v});
            apb(1'b0, `TCPC_ADDR_CLOCK_CTRL, 32'h0000_0000);
            check("clock ctrl", rd, {24'h00_0000, v});
        end
        foreach (pss[i]) begin
            p = pss[i] > 1 ? 0 : $urandom_range(3, 1);
            setup({`TCPC_SRC_INSTR, 1'(i % 2), 4'(pss[i])}, 8'h80 | 8'(i % 2), 8'(p));
            e = (p + 1) * (4 << pss[i]) * (1 + i % 2);
            wait_flag(3 * e);
            c = t0;
            apb(1'b1, `TCPC_ADDR_IRQ_STATUS, 32'h0000_0001);
            wait_flag(3 * e);
            check("overflow period", t0 - c, e);
            apb(1'b0, `TCPC_ADDR_PERIOD_HIGH, 32'h0000_0000);
            check("period", rd, p);
        end
        setup({`TCPC_SRC_INSTR, 1'b1, 4'h0}, 8'h90, 8'hFF);
        wait_flag(100);
        apb(1'b0, `TCPC_ADDR_PERIOD_HIGH, 32'h0000_0000);
        check("wide high", rd, 32'h0000_0000);
        apb(1'b1, `TCPC_ADDR_IRQ_MASK, 32'h0000_0001);
        @(posedge ref_clk);
        check("irq on", timer_irq, 1'b1);
        apb(1'b1, `TCPC_ADDR_IRQ_MASK, 32'h0000_0000);
        @(posedge ref_clk);
        check("irq off", timer_irq, 1'b0);
        for (c = 0; c < 8; c++) begin
            if (c == 2) continue;
            m = c == 5 ? 5'h1F : 5'(1 << (c < 2 ? 0 : c == 6 ? 3 : c == 7 ? 4 : c - 2));
            setup({3'(c), 1'($urandom), 4'h0}, 8'h80, 8'h03);
            pulse(~m);
            check("flag others", timer_overflow_flag, 1'b0);
            pulse(m);
            check("flag own", timer_overflow_flag, c != 1 && c != 5);
            src <= 5'h00;
            repeat (16) @(posedge ref_clk);
            check("flag end", timer_overflow_flag, c != 5);
        end
        close_out();
    end
endmodule
bind tcpc_top tcpc_chk #(.PS_W(PS_W), .PS_CNT_W(PS_CNT_W)) u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata), .timer_out(timer_out), .timer_overflow_flag(timer_overflow_flag), .timer_irq(timer_irq));
`default_nettype wire
